// ### hw/rtcp_host_port.sv
// What this block does
// - Address latches without select, no transfer
// - Address captured on address strobe falling edge
// - Write strobe low interval stores bus data
// - Bus driven with read data during read
// - Interrupt low while enabled flag set
// - Interrupt undriven when nothing enabled pending
// - Supply absent: kickstart or wake powers on
// - Supply present: power output follows software; a kickstart or wake hold keeps it on until software asserts
// - Supply absent: key falling edge requests power if auxiliary battery enabled
// - Supply present: key acts as interrupt
// - Read ends, bus released when strobe rises
`timescale 1ns/1ps
`include "rtcp_defs.svh"

module rtcp_host_port (
	input wire logic CLK,
	input wire logic RST,
	input wire logic CS_N,
	input wire logic ALE,
	input wire logic WR_N,
	input wire logic RD_N,
	input wire rtcp_pkg::rtcp_byte_type ADDR_DATA_BUS_I,
	output rtcp_pkg::rtcp_byte_type ADDR_DATA_BUS_O,
	output logic ADDR_DATA_BUS_OE_N,
	output rtcp_pkg::rtcp_byte_type REG_ADDR,
	output rtcp_pkg::rtcp_byte_type REG_WDATA,
	output logic REG_WE,
	output logic REG_RE,
	input wire rtcp_pkg::rtcp_byte_type REG_RDATA,
	output logic ADDR_LATCHED,
	output logic CS_VIOLATION,
	input wire rtcp_pkg::rtcp_irq_vec_type IRQ_FLAGS,
	input wire rtcp_pkg::rtcp_irq_vec_type IRQ_ENABLES,
	output logic IRQ_O,
	output logic IRQ_OE_N,
	input wire logic MAIN_SUPPLY_OK,
	input wire logic WAKE_KEY_N,
	input wire logic WAKE_IRQ,
	input wire logic AUX_BATTERY_ENABLE,
	input wire logic SW_POWER_ON,
	output logic POWER_ON_REQUEST_N,
	output logic WAKE_KEY_IRQ
);
	import rtcp_pkg::*;

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [`RTCP_SYNC_WIDTH-1:0] pins_async;
	logic [`RTCP_SYNC_WIDTH-1:0] pins_sync;

	assign pins_async = {MAIN_SUPPLY_OK, WAKE_KEY_N, RD_N, WR_N, ALE, CS_N, ADDR_DATA_BUS_I};

	rtcp_sync u_sync (
		.clk(CLK),
		.rst(RST),
		.async_in(pins_async),
		.sync_out(pins_sync)
	);

	logic cs_n_s;
	logic ale_s;
	logic wr_n_s;
	logic rd_n_s;
	logic key_n_s;
	logic supply_s;
	rtcp_byte_type ad_s;

	assign cs_n_s = pins_sync[`RTCP_SYNC_CS_N];
	assign ale_s = pins_sync[`RTCP_SYNC_ALE];
	assign wr_n_s = pins_sync[`RTCP_SYNC_WR_N];
	assign rd_n_s = pins_sync[`RTCP_SYNC_RD_N];
	assign key_n_s = pins_sync[`RTCP_SYNC_KEY_N];
	assign supply_s = pins_sync[`RTCP_SYNC_SUPPLY];
	assign ad_s = pins_sync[`RTCP_SYNC_AD_MSB:`RTCP_SYNC_AD_LSB];

	// ----------------------------------------
	// Power-on control and kickstart
	// ----------------------------------------
	rtcp_power u_power (
		.clk(CLK),
		.rst(RST),
		.supply_ok(supply_s),
		.wake_key_n(key_n_s),
		.wake_irq(WAKE_IRQ),
		.aux_battery_enable(AUX_BATTERY_ENABLE),
		.sw_power_on(SW_POWER_ON),
		.power_on_request_n(POWER_ON_REQUEST_N),
		.key_irq(WAKE_KEY_IRQ)
	);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic fell(input logic prev, input logic now);
		fell = prev & ~now;
	endfunction : fell

	function automatic logic rose(input logic prev, input logic now);
		rose = ~prev & now;
	endfunction : rose

	// ----------------------------------------
	// Bus port state
	// ----------------------------------------
	rtcp_port_state_type s_reg;
	rtcp_port_state_type s_next;
	logic ale_fall;
	logic rd_fall;
	logic rd_rise;
	logic wr_fall;
	logic wr_rise;
	logic cs_on;
	logic irq_pending;

	always_comb begin
		s_next = s_reg;
		ale_fall = fell(s_reg.ale_d, ale_s);
		rd_fall = fell(s_reg.rd_n_d, rd_n_s);
		rd_rise = rose(s_reg.rd_n_d, rd_n_s);
		wr_fall = fell(s_reg.wr_n_d, wr_n_s);
		wr_rise = rose(s_reg.wr_n_d, wr_n_s);
		cs_on = ~cs_n_s;
		irq_pending = |(IRQ_FLAGS & IRQ_ENABLES);

		s_next.ale_d = ale_s;
		s_next.rd_n_d = rd_n_s;
		s_next.wr_n_d = wr_n_s;
		s_next.reg_we = 1'b0;
		s_next.reg_re = 1'b0;
		s_next.addr_latched = 1'b0;
		s_next.cs_violation = 1'b0;

		// Address is taken whether or not the chip is selected
		if (ale_fall) begin
			s_next.addr = ad_s;
			s_next.addr_latched = 1'b1;
		end

		case (s_reg.state)
			RTCP_IDLE: begin
				s_next.ad_oe_n = `RTCP_OE_OFF;
				if (rd_fall && cs_on) begin
					s_next.state = RTCP_READ;
					s_next.reg_addr = s_reg.addr;
					s_next.reg_re = 1'b1;
				end else if (wr_fall && cs_on) begin
					s_next.state = RTCP_WRITE;
					s_next.reg_addr = s_reg.addr;
					s_next.wdata = ad_s;
				end else if ((rd_fall || wr_fall) && !cs_on) begin
					s_next.cs_violation = 1'b1;
				end
			end
			RTCP_READ: begin
				if (rd_rise || !cs_on) begin
					// Release on strobe end; losing select also ends the cycle
					s_next.state = RTCP_IDLE;
					s_next.ad_oe_n = `RTCP_OE_OFF;
					s_next.cs_violation = !cs_on && !rd_rise;
				end else begin
					s_next.ad_out = REG_RDATA;
					s_next.ad_oe_n = `RTCP_OE_ON;
				end
			end
			RTCP_WRITE: begin
				if (!cs_on && !wr_rise) begin
					// Select dropped mid-strobe: the write is discarded
					s_next.state = RTCP_ABORT;
					s_next.cs_violation = 1'b1;
				end else if (wr_rise) begin
					s_next.state = RTCP_IDLE;
					s_next.reg_wdata = s_reg.wdata;
					s_next.reg_we = 1'b1;
				end else begin
					// Keep the latest sample so the late part of the pulse wins
					s_next.wdata = ad_s;
				end
			end
			RTCP_ABORT: begin
				if (wr_n_s) begin
					s_next.state = RTCP_IDLE;
				end
			end
			default: begin
				s_next.state = RTCP_IDLE;
				s_next.ad_oe_n = `RTCP_OE_OFF;
			end
		endcase

		// Open drain: the line is only ever pulled low
		s_next.irq_out = 1'b0;
		s_next.irq_oe_n = irq_pending ? `RTCP_OE_ON : `RTCP_OE_OFF;
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			s_reg <= '{
				state: RTCP_IDLE,
				ale_d: 1'b0,
				rd_n_d: 1'b1,
				wr_n_d: 1'b1,
				addr: `RTCP_ADDR_RESET,
				wdata: `RTCP_DATA_RESET,
				ad_out: `RTCP_DATA_RESET,
				ad_oe_n: `RTCP_OE_OFF,
				reg_addr: `RTCP_ADDR_RESET,
				reg_wdata: `RTCP_DATA_RESET,
				reg_we: 1'b0,
				reg_re: 1'b0,
				addr_latched: 1'b0,
				cs_violation: 1'b0,
				irq_out: 1'b0,
				irq_oe_n: `RTCP_OE_OFF
			};
		end else begin
			s_reg <= s_next;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign ADDR_DATA_BUS_O = s_reg.ad_out;
	assign ADDR_DATA_BUS_OE_N = s_reg.ad_oe_n;
	assign REG_ADDR = s_reg.reg_addr;
	assign REG_WDATA = s_reg.reg_wdata;
	assign REG_WE = s_reg.reg_we;
	assign REG_RE = s_reg.reg_re;
	assign ADDR_LATCHED = s_reg.addr_latched;
	assign CS_VIOLATION = s_reg.cs_violation;
	assign IRQ_O = s_reg.irq_out;
	assign IRQ_OE_N = s_reg.irq_oe_n;

endmodule : rtcp_host_port

// ### hw/rtcp_defs.svh
`ifndef RTCP_DEFS_SVH
`define RTCP_DEFS_SVH

// ----------------------------------------
// Widths
// ----------------------------------------
`define RTCP_AD_WIDTH 8
`define RTCP_IRQ_WIDTH 8
`define RTCP_SYNC_WIDTH 14

// ----------------------------------------
// Positions inside the synchronised pin vector
// ----------------------------------------
`define RTCP_SYNC_AD_LSB 0
`define RTCP_SYNC_AD_MSB 7
`define RTCP_SYNC_CS_N 8
`define RTCP_SYNC_ALE 9
`define RTCP_SYNC_WR_N 10
`define RTCP_SYNC_RD_N 11
`define RTCP_SYNC_KEY_N 12
`define RTCP_SYNC_SUPPLY 13

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RTCP_SYNC_RESET 14'h3d00
`define RTCP_ADDR_RESET 8'h00
`define RTCP_DATA_RESET 8'h00
`define RTCP_OE_OFF 1'b1
`define RTCP_OE_ON 1'b0
`define RTCP_PWR_OFF_N 1'b1

`endif

// ### hw/rtcp_pkg.sv
`include "rtcp_defs.svh"

package rtcp_pkg;

	// ----------------------------------------
	// Bus cycle states
	// ----------------------------------------
	typedef enum logic [1:0] {
		RTCP_IDLE,
		RTCP_READ,
		RTCP_WRITE,
		RTCP_ABORT
	} rtcp_bus_state_type;

	typedef logic [`RTCP_AD_WIDTH-1:0] rtcp_byte_type;
	typedef logic [`RTCP_IRQ_WIDTH-1:0] rtcp_irq_vec_type;

	// ----------------------------------------
	// Register state of the bus port
	// ----------------------------------------
	typedef struct packed {
		rtcp_bus_state_type state;
		logic ale_d;
		logic rd_n_d;
		logic wr_n_d;
		rtcp_byte_type addr;
		rtcp_byte_type wdata;
		rtcp_byte_type ad_out;
		logic ad_oe_n;
		rtcp_byte_type reg_addr;
		rtcp_byte_type reg_wdata;
		logic reg_we;
		logic reg_re;
		logic addr_latched;
		logic cs_violation;
		logic irq_out;
		logic irq_oe_n;
	} rtcp_port_state_type;

	// ----------------------------------------
	// Register state of the power control
	// ----------------------------------------
	typedef struct packed {
		logic key_n_d;
		logic held_on;
		logic power_n;
		logic key_irq;
	} rtcp_power_state_type;

endpackage : rtcp_pkg

// ### hw/rtcp_sync.sv
`timescale 1ns/1ps
`include "rtcp_defs.svh"

module rtcp_sync (
	input wire logic clk,
	input wire logic rst,
	input wire logic [`RTCP_SYNC_WIDTH-1:0] async_in,
	output logic [`RTCP_SYNC_WIDTH-1:0] sync_out
);
	import rtcp_pkg::*;

	logic [`RTCP_SYNC_WIDTH-1:0] meta_reg;

	// Idle levels at reset keep strobes inactive until the pins are seen
	always_ff @(posedge clk) begin
		if (rst) begin
			meta_reg <= `RTCP_SYNC_RESET;
			sync_out <= `RTCP_SYNC_RESET;
		end else begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end

endmodule : rtcp_sync

// ### hw/rtcp_power.sv
`timescale 1ns/1ps
`include "rtcp_defs.svh"

module rtcp_power (
	input wire logic clk,
	input wire logic rst,
	input wire logic supply_ok,
	input wire logic wake_key_n,
	input wire logic wake_irq,
	input wire logic aux_battery_enable,
	input wire logic sw_power_on,
	output logic power_on_request_n,
	output logic key_irq
);
	import rtcp_pkg::*;

	rtcp_power_state_type s_reg;
	rtcp_power_state_type s_next;
	logic key_fall;

	always_comb begin
		s_next = s_reg;
		key_fall = s_reg.key_n_d & ~wake_key_n;
		s_next.key_n_d = wake_key_n;
		s_next.key_irq = 1'b0;
		if (!supply_ok) begin
			// Kickstart needs the auxiliary battery enabled by software
			if ((key_fall && aux_battery_enable) || wake_irq) begin
				s_next.held_on = 1'b1;
			end
			s_next.power_n = ~s_next.held_on;
		end else begin
			// Hold power until software takes over, so the system does not drop
			if (sw_power_on) begin
				s_next.held_on = 1'b0;
			end
			s_next.power_n = ~(sw_power_on | s_reg.held_on);
			s_next.key_irq = key_fall;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s_reg <= '{key_n_d: 1'b1, held_on: 1'b0, power_n: `RTCP_PWR_OFF_N, key_irq: 1'b0};
		end else begin
			s_reg <= s_next;
		end
	end

	assign power_on_request_n = s_reg.power_n;
	assign key_irq = s_reg.key_irq;

endmodule : rtcp_power

// ### verification/rtcp_host_port_chk.sv
`timescale 1ns/1ps

module rtcp_host_port_chk (
	input wire logic CLK,
	input wire logic RST,
	input wire logic CS_N,
	input wire logic ALE,
	input wire logic WR_N,
	input wire logic RD_N,
	input wire logic ADDR_DATA_BUS_OE_N,
	input wire logic REG_WE,
	input wire logic REG_RE,
	input wire logic ADDR_LATCHED,
	input wire rtcp_pkg::rtcp_irq_vec_type IRQ_FLAGS,
	input wire rtcp_pkg::rtcp_irq_vec_type IRQ_ENABLES,
	input wire logic IRQ_O,
	input wire logic IRQ_OE_N,
	input wire logic MAIN_SUPPLY_OK,
	input wire logic WAKE_KEY_N,
	input wire logic WAKE_IRQ,
	input wire logic AUX_BATTERY_ENABLE,
	input wire logic SW_POWER_ON,
	input wire logic POWER_ON_REQUEST_N,
	input wire logic WAKE_KEY_IRQ
);
	import rtcp_pkg::*;

	// ----------------------------------------
	// Pin timing: two sync stages plus one edge-detect register
	// ----------------------------------------
	default clocking @(posedge CLK); endclocking
	default disable iff (RST);

	addr_latch_a: assert property ($fell(ALE) |-> ##3 ADDR_LATCHED)
		else $error("address capture late");
	read_start_a: assert property ($fell(RD_N) && !CS_N |-> ##3 REG_RE ##1 !ADDR_DATA_BUS_OE_N)
		else $error("read not started");
	read_end_a: assert property ($rose(RD_N) |-> ##3 ADDR_DATA_BUS_OE_N)
		else $error("bus not released");
	bus_idle_a: assert property (RD_N [*5] |-> ADDR_DATA_BUS_OE_N)
		else $error("bus driven outside read");
	write_pulse_a: assert property ($rose(WR_N) && !CS_N |-> ##3 REG_WE ##1 !REG_WE)
		else $error("write pulse wrong");
	unselected_a: assert property (CS_N [*5] |-> !REG_WE && !REG_RE)
		else $error("transfer without select");
	irq_on_a: assert property (|(IRQ_FLAGS & IRQ_ENABLES) |=> !IRQ_OE_N && !IRQ_O)
		else $error("irq not pulled low");
	irq_off_a: assert property (!(|(IRQ_FLAGS & IRQ_ENABLES)) |=> IRQ_OE_N)
		else $error("irq driven while idle");
	wake_power_a: assert property (!MAIN_SUPPLY_OK [*4] ##0 WAKE_IRQ |=> !POWER_ON_REQUEST_N)
		else $error("wake did not power on");
	key_power_a: assert property ($fell(WAKE_KEY_N) && AUX_BATTERY_ENABLE && !MAIN_SUPPLY_OK
		&& !$past(MAIN_SUPPLY_OK, 3) |-> ##3 !POWER_ON_REQUEST_N)
		else $error("key did not power on");
	key_irq_a: assert property ($fell(WAKE_KEY_N) && MAIN_SUPPLY_OK && $past(MAIN_SUPPLY_OK, 3)
		|-> ##3 WAKE_KEY_IRQ ##1 !WAKE_KEY_IRQ)
		else $error("key interrupt wrong");
	sw_power_a: assert property (MAIN_SUPPLY_OK [*4] ##0 SW_POWER_ON |=> !POWER_ON_REQUEST_N)
		else $error("power ignores software");

	cover property (REG_WE);
	cover property (REG_RE);
	cover property ($fell(POWER_ON_REQUEST_N));
endmodule : rtcp_host_port_chk

bind rtcp_host_port rtcp_host_port_chk chk (.*);

// ### verification/rtcp_host_model.sv
`timescale 1ns/1ps

module rtcp_host_model (
	input wire logic clk,
	input wire rtcp_pkg::rtcp_byte_type bus_in,
	output logic cs_n,
	output logic ale,
	output logic wr_n,
	output logic rd_n,
	output rtcp_pkg::rtcp_byte_type ad_out
);
	import rtcp_pkg::*;

	initial begin
		cs_n = 1'b1;
		ale = 1'b0;
		wr_n = 1'b1;
		rd_n = 1'b1;
		ad_out = 8'h00;
	end

	// ----------------------------------------
	// One bus cycle; address phases last 4 clocks and the strobe 7, so the synchronisers see each
	// ----------------------------------------
	task automatic cycle(input logic wr, input logic sel, input rtcp_byte_type a,
		input rtcp_byte_type d, output rtcp_byte_type q);
		@(posedge clk);
		cs_n <= !sel;
		ale <= 1'b1;
		ad_out <= a;
		repeat (4) @(posedge clk);
		ale <= 1'b0;
		repeat (4) @(posedge clk);
		ad_out <= wr ? d : ~a;
		wr_n <= !wr;
		rd_n <= wr;
		repeat (6) @(posedge clk);
		@(negedge clk);
		q = bus_in;
		@(posedge clk);
		wr_n <= 1'b1;
		rd_n <= 1'b1;
		repeat (4) @(posedge clk);
		cs_n <= 1'b1;
		// Released lines show a changed pattern, never the last value
		ad_out <= ~ad_out;
		repeat (4) @(posedge clk);
	endtask : cycle
endmodule : rtcp_host_model

// ### verification/tb_rtcp_host_port.sv
`timescale 1ns/1ps

module tb_rtcp_host_port;
	import rtcp_pkg::*;

	typedef struct packed {logic wr; rtcp_byte_type a; rtcp_byte_type d;} rtcp_row_type;
	logic clk, rst, supply, key_n, wake, aux, sw_on;
	logic cs_n, ale, wr_n, rd_n, oe_n, we, re, lat, vio, irq_o, irq_oe_n, pwr_n, key_irq;
	rtcp_byte_type host_ad, dev_ad, bus, reg_addr, reg_wdata, rdata, q;
	rtcp_irq_vec_type flags, enables;
	int errors, tests_run, n_we, n_lat, n_vio, n_key;
	rtcp_row_type rows [4] = '{'{1'b1, 8'ha5, 8'h3c}, '{1'b0, 8'h7f, 8'h25},
		'{1'b1, 8'h00, 8'hff}, '{1'b0, 8'h80, 8'hda}};

	assign bus = (oe_n === 1'b0) ? dev_ad : host_ad;

	rtcp_host_port uut (.CLK(clk), .RST(rst), .CS_N(cs_n), .ALE(ale), .WR_N(wr_n), .RD_N(rd_n),
		.ADDR_DATA_BUS_I(bus), .ADDR_DATA_BUS_O(dev_ad), .ADDR_DATA_BUS_OE_N(oe_n),
		.REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WE(we), .REG_RE(re), .REG_RDATA(rdata),
		.ADDR_LATCHED(lat), .CS_VIOLATION(vio), .IRQ_FLAGS(flags), .IRQ_ENABLES(enables),
		.IRQ_O(irq_o), .IRQ_OE_N(irq_oe_n), .MAIN_SUPPLY_OK(supply), .WAKE_KEY_N(key_n),
		.WAKE_IRQ(wake), .AUX_BATTERY_ENABLE(aux), .SW_POWER_ON(sw_on),
		.POWER_ON_REQUEST_N(pwr_n), .WAKE_KEY_IRQ(key_irq));

	rtcp_host_model host (.clk(clk), .bus_in(bus), .cs_n(cs_n), .ale(ale), .wr_n(wr_n),
		.rd_n(rd_n), .ad_out(host_ad));

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// ----------------------------------------
	// Register file stand-in and pulse counters
	// ----------------------------------------
	always @(posedge clk) rdata <= reg_addr ^ 8'h5a;

	always @(negedge clk) begin
		n_we += int'(we === 1'b1);
		n_lat += int'(lat === 1'b1);
		n_vio += int'(vio === 1'b1);
		n_key += int'(key_irq === 1'b1);
	end

	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("unexpected %s: expected %h, seen %h", name, exp, got);
		end
	endtask : chk

	task automatic step(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask : step

	task automatic finish_test();
		$display("checks %0d, errors %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : finish_test

	initial begin
		repeat (20000) @(posedge clk);
		errors++;
		finish_test();
	end

	initial begin
		rst = 1'b1;
		flags = 8'h00;
		enables = 8'h00;
		supply = 1'b1;
		key_n = 1'b1;
		wake = 1'b0;
		aux = 1'b1;
		sw_on = 1'b0;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		step(0);
		chk("bus enable", 8'h01, oe_n);
		chk("irq enable", 8'h01, irq_oe_n);
		chk("power", 8'h01, pwr_n);
		foreach (rows[i]) begin
			host.cycle(rows[i].wr, 1'b1, rows[i].a, rows[i].d, q);
			if (rows[i].wr) begin
				chk("write addr", rows[i].a, reg_addr);
				chk("write data", rows[i].d, reg_wdata);
			end else begin
				chk("read data", rows[i].d, q);
			end
		end
		chk("writes", 8'h02, 8'(n_we));
		chk("bus released", 8'h01, oe_n);
		host.cycle(1'b1, 1'b0, 8'h11, 8'h99, q);
		chk("latches", 8'h05, 8'(n_lat));
		chk("unselected writes", 8'h02, 8'(n_we));
		chk("select fault", 8'h01, 8'(n_vio));
		for (int i = 0; i < 8; i++) begin
			@(posedge clk);
			flags <= 8'h01 << i;
			enables <= 8'h01 << i;
			step(1);
			chk("irq driven", 8'h00, {irq_o, irq_oe_n});
			@(posedge clk);
			enables <= ~(8'h01 << i);
			step(1);
			chk("irq masked", 8'h01, irq_oe_n);
		end
		@(posedge clk);
		flags <= 8'h81;
		enables <= 8'hff;
		step(1);
		chk("irq two flags", 8'h00, irq_oe_n);
		@(posedge clk);
		flags <= 8'h80;
		step(1);
		chk("irq one flag left", 8'h00, irq_oe_n);
		@(posedge clk);
		flags <= 8'h00;
		step(1);
		chk("irq released", 8'h01, irq_oe_n);
		@(posedge clk);
		supply <= 1'b0;
		aux <= 1'b0;
		step(4);
		@(posedge clk);
		key_n <= 1'b0;
		step(4);
		chk("key gated", 8'h01, pwr_n);
		@(posedge clk);
		key_n <= 1'b1;
		aux <= 1'b1;
		step(4);
		@(posedge clk);
		key_n <= 1'b0;
		step(4);
		chk("key power", 8'h00, pwr_n);
		@(posedge clk);
		key_n <= 1'b1;
		supply <= 1'b1;
		sw_on <= 1'b1;
		step(4);
		chk("sw power on", 8'h00, pwr_n);
		@(posedge clk);
		sw_on <= 1'b0;
		step(4);
		chk("sw power off", 8'h01, pwr_n);
		@(posedge clk);
		key_n <= 1'b0;
		step(4);
		chk("key irq", 8'h01, 8'(n_key));
		chk("power kept off", 8'h01, pwr_n);
		@(posedge clk);
		key_n <= 1'b1;
		supply <= 1'b0;
		step(4);
		@(posedge clk);
		wake <= 1'b1;
		step(2);
		chk("wake power", 8'h00, pwr_n);
		finish_test();
	end
endmodule : tb_rtcp_host_port
